// file: design/byte_demux_pkg.sv
package byte_demux_pkg;
    // ----------------------------------------
    // widths and reset values
    // ----------------------------------------
    localparam int data_width = 8;
    localparam int cmd_width = 4;
    localparam int bytes_per_word = 4;
    localparam int fifo_depth = 4;
    localparam logic [7:0] data_reset = 8'h00;
    localparam logic [3:0] cmd_reset = 4'h0;
    localparam logic [3:0] zero_command = 4'h0;
endpackage : byte_demux_pkg

// file: design/byte_to_word_demux.sv
// Behaviour
// RULE_01 - bytes gathered in arrival order, delivered four at a time together as one 32-bit word
// RULE_02 - works for blocks of any length, four bytes to 64K, between syncs
// RULE_03 - one-hot sequencer advances per byte; each stage loads one capture slot
// RULE_04 - marker leaving stage four raises flush pending; next edge transfers all
// RULE_05 - sequencer advances on data strobe or command strobe
// RULE_06 - receiver pulses command strobe with zero command lines on sync
// RULE_07 - command strobe with zero command lines is sync; asserts stage clear
// RULE_08 - stage clear registered into sync seen, which raises flush pending
// RULE_09 - sync flush fires next edge unless stage four already fired
// RULE_10 - sync transfers only partial groups; full groups transfer by stage four
// RULE_11 - repeated syncs hold sequencer in reset, outputs unchanged
// RULE_12 - sender gives a sync before each block for stage-one alignment
// RULE_13 - transmitter inserts sync in every idle byte period
// RULE_14 - stage clear acts before the sequencer can load a capture slot
// RULE_15 - 4-bit command capture and output per byte on same clocks
// RULE_16 - data strobe level kept per byte: high data, low command
// RULE_17 - violation flag kept per byte as error indication
// RULE_18 - non-sync command keeps last data value; data byte keeps last command
// RULE_19 - bytes per word is a parameter
// RULE_20 - reset clears sequencer, flush and sync state, zeroes out_r, word_valid, overflow; word fields come from uncleared FIFO memory
`timescale 1ns/1ps

module word_fifo #(
    parameter int width = 8,
    parameter int depth = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [width-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [width-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem_r [depth];
    logic [width-1:0] mem_nxt [depth];
    logic [aw-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
    logic [aw:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = cnt_r != (aw+1)'(depth);
    assign out_valid = cnt_r != '0;
    assign out_data = mem_r[rd_r];

    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        mem_nxt = mem_r;
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        if (push)
        begin
            mem_nxt[wr_r] = in_data;
            wr_nxt = (wr_r == aw'(depth - 1)) ? '0 : wr_r + 1'b1;
        end
        if (pop)
        begin
            rd_nxt = (rd_r == aw'(depth - 1)) ? '0 : rd_r + 1'b1;
        end
        cnt_nxt = cnt_r + (aw+1)'(push) - (aw+1)'(pop);
    end

    always_ff @(posedge core_clk)
    begin
        mem_r <= mem_nxt;
        if (rst)
        begin
            rd_r <= '0;
            wr_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule : word_fifo

module capture_slot #(
    parameter int width = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [width-1:0] in_data,
    output logic [width-1:0] out_data
);
    logic [width-1:0] slot_r, slot_nxt;

    always_comb
    begin
        slot_nxt = slot_r;
        if (load)
            slot_nxt = in_data;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            slot_r <= '0;
        else
            slot_r <= slot_nxt;
    end

    assign out_data = slot_r;
endmodule : capture_slot

module byte_to_word_demux #(
    parameter int num_bytes = byte_demux_pkg::bytes_per_word,
    parameter int dw = byte_demux_pkg::data_width,
    parameter int cw = byte_demux_pkg::cmd_width
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic data_byte_strobe,
    input wire logic command_byte_strobe,
    input wire logic [dw-1:0] rx_data,
    input wire logic [cw-1:0] rx_command,
    input wire logic code_violation_flag,
    output logic word_output_clock,
    output logic [num_bytes*dw-1:0] word_data,
    output logic [num_bytes*cw-1:0] word_command,
    output logic [num_bytes-1:0] word_is_data,
    output logic [num_bytes-1:0] word_error,
    output logic word_valid,
    input wire logic word_ready,
    output logic overflow
);
    localparam int lw = dw + cw + 2;
    localparam int ww = num_bytes * lw;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic ds_s1_r, ds_r, cs_s1_r, cs_r, vf_s1_r, vf_r;
    logic [dw-1:0] d_s1_r, d_r;
    logic [cw-1:0] c_s1_r, c_r;
    logic strobe_prev_r;

    always_ff @(posedge core_clk)
    begin
        ds_s1_r <= data_byte_strobe;
        ds_r <= ds_s1_r;
        cs_s1_r <= command_byte_strobe;
        cs_r <= cs_s1_r;
        vf_s1_r <= code_violation_flag;
        vf_r <= vf_s1_r;
        d_s1_r <= rx_data;
        d_r <= d_s1_r;
        c_s1_r <= rx_command;
        c_r <= c_s1_r;
    end

    // ----------------------------------------
    // sequencer and capture
    // ----------------------------------------
    logic sequencer_clock, zero_command_detect, stage_clear, byte_edge;
    logic [num_bytes-1:0] stage_r, stage_nxt, stage_capture_clock;
    logic fourth_stage_clock;
    logic [lw-1:0] cap_in;
    logic [lw-1:0] cap_q [num_bytes];
    logic sync_seen_r, sync_seen_nxt, partial_r, partial_nxt;
    logic flush_pending_r, flush_pending_nxt;
    logic woc_r, woc_nxt;
    logic [ww-1:0] out_r, out_nxt;
    logic strobe_prev_nxt;
    logic fifo_in_ready, fifo_push;

    always_comb
    begin
        // RULE_05 strobe or
        sequencer_clock = ds_r | cs_r;
        byte_edge = sequencer_clock & ~strobe_prev_r;
        strobe_prev_nxt = sequencer_clock;
        // RULE_07 sync detect
        zero_command_detect = c_r == byte_demux_pkg::zero_command;
        stage_clear = cs_r & zero_command_detect;
        // RULE_14 clear before capture
        stage_capture_clock = (byte_edge && !stage_clear) ? stage_r : '0;
        fourth_stage_clock = stage_capture_clock[num_bytes-1];
        // RULE_03 one-hot advance
        stage_nxt = stage_r;
        if (stage_clear)
            stage_nxt = {{(num_bytes-1){1'b0}}, 1'b1};
        else if (byte_edge)
            stage_nxt = {stage_r[num_bytes-2:0], stage_r[num_bytes-1]};
    end

    // RULE_20 back to stage one
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            strobe_prev_r <= 1'b0;
            stage_r <= {{(num_bytes-1){1'b0}}, 1'b1};
        end
        else
        begin
            strobe_prev_r <= strobe_prev_nxt;
            stage_r <= stage_nxt;
        end
    end

    // ----------------------------------------
    // capture column
    // ----------------------------------------
    // RULE_15 command capture; RULE_16 type bit; RULE_17 error bit
    // RULE_18 fields keep last receiver values via shared pins
    assign cap_in = {vf_r, ds_r, c_r, d_r};

    for (genvar g = 0; g < num_bytes; g = g + 1)
    begin : g_slot
        capture_slot #(.width(lw)) u_slot (
            .core_clk(core_clk),
            .rst(rst),
            .load(stage_capture_clock[g]),
            .in_data(cap_in),
            .out_data(cap_q[g])
        );
    end

    // ----------------------------------------
    // flush control and output column
    // ----------------------------------------
    always_comb
    begin
        // RULE_08 sync seen
        sync_seen_nxt = stage_clear & byte_edge;
        // open group remembered, sampled from stage_r before the clear resets the stages
        partial_nxt = !stage_r[0];
        // RULE_04 RULE_10 flush sources; partial group only for sync
        flush_pending_nxt = fourth_stage_clock |
            (sync_seen_r && partial_r && !woc_r);
        // RULE_09 RULE_11 output clock, held high while the flushing sync's stage clear lasts
        woc_nxt = flush_pending_r | (woc_r & stage_clear);
        // RULE_01 all bytes transfer at once
        out_nxt = out_r;
        fifo_push = flush_pending_r && !woc_r;
        if (fifo_push)
            for (int i = 0; i < num_bytes; i++)
                out_nxt[i*lw +: lw] = cap_q[i];
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            // RULE_20 reset state
            sync_seen_r <= 1'b0;
            partial_r <= 1'b0;
            flush_pending_r <= 1'b0;
            woc_r <= 1'b0;
            out_r <= '0;
        end
        else
        begin
            sync_seen_r <= sync_seen_nxt;
            partial_r <= partial_nxt;
            flush_pending_r <= flush_pending_nxt;
            woc_r <= woc_nxt;
            out_r <= out_nxt;
        end
    end

    // ----------------------------------------
    // output fifo
    // ----------------------------------------
    logic [ww-1:0] fifo_out;
    logic overflow_r, overflow_nxt;

    // RULE_02 stream of any length, no counter limit
    word_fifo #(.width(ww), .depth(byte_demux_pkg::fifo_depth)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_data(out_nxt),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(word_valid),
        .out_ready(word_ready)
    );

    always_comb
    begin
        overflow_nxt = overflow_r | (fifo_push & ~fifo_in_ready);
        // RULE_19 column width follows parameter
        for (int i = 0; i < num_bytes; i++)
        begin
            word_data[i*dw +: dw] = fifo_out[i*lw +: dw];
            word_command[i*cw +: cw] = fifo_out[i*lw+dw +: cw];
            word_is_data[i] = fifo_out[i*lw+dw+cw];
            word_error[i] = fifo_out[i*lw+dw+cw+1];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            overflow_r <= 1'b0;
        else
            overflow_r <= overflow_nxt;
    end

    assign word_output_clock = woc_r;
    assign overflow = overflow_r;
endmodule : byte_to_word_demux

// file: dv/byte_to_word_demux_chk.sv
`timescale 1ns/1ps
module byte_to_word_demux_chk #(
    parameter int num_bytes = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic data_byte_strobe,
    input wire logic command_byte_strobe,
    input wire logic word_output_clock,
    input wire logic [num_bytes*8-1:0] word_data,
    input wire logic [num_bytes*4-1:0] word_command,
    input wire logic [num_bytes-1:0] word_is_data,
    input wire logic [num_bytes-1:0] word_error,
    input wire logic word_valid,
    input wire logic word_ready,
    input wire logic overflow
);
    // ----------------------------------------
    // cycles since last strobe, then checks
    // ----------------------------------------
    logic [3:0] idle_r;
    logic [3:0] idle_nxt;
    always_comb
    begin
        idle_nxt = idle_r;
        if (data_byte_strobe | command_byte_strobe)
            idle_nxt = 4'h0;
        else if (idle_r != 4'hf)
            idle_nxt = idle_r + 4'h1;
    end
    always_ff @(posedge core_clk)
    begin
        idle_r <= rst ? 4'hf : idle_nxt;
    end
    default clocking cb @(posedge core_clk); endclocking
    chk_reset_clear: assert property (rst |=> !word_valid && !overflow)
        else $error("outputs not cleared by reset");
    chk_reset_clock: assert property (rst |=> !word_output_clock)
        else $error("word clock high after reset");
    chk_flag_sticky: assert property (disable iff (rst) overflow |=> overflow)
        else $error("overflow cleared");
    chk_flag_cause: assert property (disable iff (rst) $rose(overflow) |-> word_valid)
        else $error("overflow without full buffer");
    chk_hold_fields: assert property (disable iff (rst) word_valid && !word_ready
        |=> word_valid && $stable(word_data) && $stable(word_command))
        else $error("word fields moved while waiting");
    chk_hold_flags: assert property (disable iff (rst) word_valid && !word_ready
        |=> $stable(word_is_data) && $stable(word_error))
        else $error("word flags moved while waiting");
    chk_pop_only: assert property (disable iff (rst) $fell(word_valid) |-> $past(word_ready))
        else $error("word vanished without pop");
    chk_clock_cause: assert property (disable iff (rst) $rose(word_output_clock) |-> idle_r <= 4'h9)
        else $error("word clock without a byte");
endmodule : byte_to_word_demux_chk

// file: dv/byte_to_word_demux_test.sv
`timescale 1ns/1ps
module byte_to_word_demux_test;
    // ----------------------------------------
    // stimulus and checks
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic send = 1'b0;
    logic [13:0] s_req = 14'h0000;
    logic word_ready = 1'b0;
    logic dstb, cstb, vflag, woc, wv, ovf;
    logic [7:0] rxd;
    logic [3:0] rxc, wi, we;
    logic [31:0] wd;
    logic [15:0] wc;
    int fails = 0;
    int tests_run = 0;
    int woc_rises = 0;
    logic [31:0] rows [4] = '{32'h04030201, 32'hffeedd00, 32'h80402010, 32'h5aa5c33c};
    rx_byte_source src (.core_clk(core_clk), .send(send), .s_is_data(s_req[13]), .s_data(s_req[12:5]),
        .s_cmd(s_req[4:1]), .s_err(s_req[0]), .data_byte_strobe(dstb), .command_byte_strobe(cstb),
        .rx_data(rxd), .rx_command(rxc), .code_violation_flag(vflag));
    byte_to_word_demux uut (.core_clk(core_clk), .rst(rst), .data_byte_strobe(dstb), .command_byte_strobe(cstb),
        .rx_data(rxd), .rx_command(rxc), .code_violation_flag(vflag), .word_output_clock(woc), .word_data(wd),
        .word_command(wc), .word_is_data(wi), .word_error(we), .word_valid(wv), .word_ready(word_ready),
        .overflow(ovf));
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge woc)
    begin
        woc_rises <= woc_rises + 1;
    end
    task automatic give_verdict();
        if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic put(input logic d, input logic [7:0] v, input logic [3:0] c, input logic e);
        send <= 1'b1;
        s_req <= {d, v, c, e};
        @(posedge core_clk);
        send <= 1'b0;
        repeat (12) @(posedge core_clk);
    endtask : put
    task automatic pop(input logic [31:0] d, input logic [15:0] c, input logic [3:0] i, input logic [3:0] e);
        int n;
        n = 0;
        while (wv !== 1'b1 && n < 40)
        begin
            @(posedge core_clk);
            n++;
        end
        cmp({31'h0, wv}, 32'h1);
        cmp(wd, d);
        cmp({16'h0, wc}, {16'h0, c});
        cmp({24'h0, wi, we}, {24'h0, i, e});
        word_ready <= 1'b1;
        @(posedge core_clk);
        word_ready <= 1'b0;
        @(posedge core_clk);
    endtask : pop
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        cmp({30'h0, wv, ovf}, 32'h0);
        for (int r = 0; r < 4; r++)
        begin
            put(1'b0, 8'h00, 4'h0, 1'b0);
            for (int b = 0; b < 4; b++)
                put(1'b1, rows[r][b*8 +: 8], 4'h0, b == r);
            pop(rows[r], 16'h0000, 4'hf, 4'h1 << r);
        end
        put(1'b0, 8'h00, 4'h0, 1'b0);
        put(1'b1, 8'h11, 4'h0, 1'b0);
        put(1'b1, 8'h22, 4'h0, 1'b0);
        put(1'b0, 8'h00, 4'h9, 1'b1);
        put(1'b0, 8'h00, 4'h0, 1'b0);
        pop(32'h5a222211, 16'h0900, 4'hb, 4'hc);
        put(1'b0, 8'h00, 4'h0, 1'b0);
        put(1'b0, 8'h00, 4'h0, 1'b0);
        cmp({31'h0, wv}, 32'h0);
        cmp(woc_rises, 32'h5);
        for (int k = 1; k < 6; k++)
            for (int b = 0; b < 4; b++)
                put(1'b1, k[7:0], 4'h0, 1'b0);
        repeat (10) @(posedge core_clk);
        cmp({31'h0, ovf}, 32'h1);
        for (int k = 1; k < 5; k++)
            pop({4{k[7:0]}}, 16'h0000, 4'hf, 4'h0);
        cmp({31'h0, wv}, 32'h0);
        cmp(woc_rises, 32'ha);
        give_verdict();
    end
    initial
    begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule : byte_to_word_demux_test
bind byte_to_word_demux byte_to_word_demux_chk #(.num_bytes(num_bytes)) chk (.core_clk(core_clk), .rst(rst),
    .data_byte_strobe(data_byte_strobe), .command_byte_strobe(command_byte_strobe),
    .word_output_clock(word_output_clock), .word_data(word_data), .word_command(word_command),
    .word_is_data(word_is_data), .word_error(word_error), .word_valid(word_valid), .word_ready(word_ready),
    .overflow(overflow));

// file: dv/rx_byte_source.sv
`timescale 1ns/1ps
module rx_byte_source (
    input wire logic core_clk,
    input wire logic send,
    input wire logic s_is_data,
    input wire logic [7:0] s_data,
    input wire logic [3:0] s_cmd,
    input wire logic s_err,
    output logic data_byte_strobe,
    output logic command_byte_strobe,
    output logic [7:0] rx_data,
    output logic [3:0] rx_command,
    output logic code_violation_flag
);
    // ----------------------------------------
    // receiver byte outputs, strobe 4 cycles
    // ----------------------------------------
    logic [3:0] cnt_r = 4'h0;
    logic kind_r = 1'b0;
    initial
    begin
        rx_data = 8'h00;
        rx_command = 4'h0;
        code_violation_flag = 1'b0;
    end
    always @(posedge core_clk)
    begin
        if (send && cnt_r == 4'h0)
        begin
            cnt_r <= 4'h1;
            kind_r <= s_is_data;
            code_violation_flag <= s_err;
            if (s_is_data)
                rx_data <= s_data;
            else
                rx_command <= s_cmd;
        end
        else if (cnt_r != 4'h0)
            cnt_r <= (cnt_r == 4'hb) ? 4'h0 : cnt_r + 4'h1;
    end
    assign command_byte_strobe = !kind_r && cnt_r >= 4'h4 && cnt_r <= 4'h7;
    assign data_byte_strobe = kind_r && cnt_r >= 4'h4 && cnt_r <= 4'h7;
endmodule : rx_byte_source
